// ### rtl/slwp_consts.svh
/*
  Constants of the late-write SRAM port: widths, depths, latencies and state codes.
  Assumes it is included by its bare name by the package and by the design modules.
*/
`ifndef SLWP_CONSTS_SVH
`define SLWP_CONSTS_SVH

// Array geometry: four lanes of nine bits, one word per address.
`define SLWP_ADDR_W      19
`define SLWP_WORDS       524288
`define SLWP_LANE_W      9
`define SLWP_LANES       4
`define SLWP_DATA_W      36

// Pending-write queue: one entry is an address plus four lane strobes.
`define SLWP_ENTRY_W     23
`define SLWP_FIFO_DEPTH  32
`define SLWP_FIFO_AW     5

// Command-to-data latency of a write, in enabled clock edges.
`define SLWP_PIPE_WR_LAT 2
`define SLWP_FLOW_WR_LAT 1

// One-hot codes of the burst control state.
`define SLWP_CMD_IDLE    3'h1
`define SLWP_CMD_READ    3'h2
`define SLWP_CMD_WRITE   3'h4

`endif

// ### rtl/slwp_pkg.sv
/*
  Types shared by the late-write SRAM port.
  Assumes slwp_consts.svh is on the include path.
*/
`include "slwp_consts.svh"

package slwp_pkg;

  // Operation carried by the current burst; a continue cycle repeats it.
  typedef enum logic [2:0] {
    SLWP_CMD_IDLE  = `SLWP_CMD_IDLE,
    SLWP_CMD_READ  = `SLWP_CMD_READ,
    SLWP_CMD_WRITE = `SLWP_CMD_WRITE
  } slwp_cmd_t;

endpackage : slwp_pkg

// ### rtl/slwp_fifo.sv
/*
  Small synchronous FIFO with a registered output slot and valid/ready on both sides.
  Assumes one clock, synchronous active-low reset and a clock enable that freezes it.
*/
`timescale 1ns/1ps
`include "slwp_consts.svh"

module slwp_fifo #(
  parameter int WIDTH = `SLWP_ENTRY_W,
  parameter int DEPTH = `SLWP_FIFO_DEPTH,
  parameter int AW    = `SLWP_FIFO_AW
) (
  input  wire logic             sys_clk,
  input  wire logic             resetn,
  input  wire logic             ce,
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  output logic                  out_valid,
  output logic      [WIDTH-1:0] out_data,
  input  wire logic             out_ready
);

  logic [WIDTH-1:0] mem [0:DEPTH-1];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    next_wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW-1:0]    next_rd_ptr;
  logic [AW:0]      count;
  logic [AW:0]      next_count;
  logic             next_out_valid;
  logic [WIDTH-1:0] next_out_data;
  logic             load_out;
  logic             take_mem;
  logic             take_direct;
  logic             push_mem;

  //////////////////////////////////////////////////////////////////////////////
  // An empty queue hands a new entry straight to the output slot, so an entry
  // pushed on one edge can be popped on the very next one.
  always_comb begin
    in_ready       = (count != (AW+1)'(DEPTH));
    load_out       = !out_valid || out_ready;
    take_mem       = load_out && (count != '0);
    take_direct    = load_out && (count == '0) && in_valid;
    push_mem       = in_valid && in_ready && !take_direct;
    next_wr_ptr    = push_mem ? AW'(wr_ptr + 1'b1) : wr_ptr;
    next_rd_ptr    = take_mem ? AW'(rd_ptr + 1'b1) : rd_ptr;
    next_count     = count;
    if (push_mem && !take_mem) begin
      next_count = (AW+1)'(count + 1'b1);
    end else if (!push_mem && take_mem) begin
      next_count = (AW+1)'(count - 1'b1);
    end
    next_out_valid = (take_mem || take_direct) ? 1'b1 : (out_valid && !out_ready);
    next_out_data  = take_mem ? mem[rd_ptr] : (take_direct ? in_data : out_data);
  end

  // Pointer, count and output slot registers.
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      wr_ptr    <= '0;
      rd_ptr    <= '0;
      count     <= '0;
      out_valid <= 1'b0;
      out_data  <= '0;
    end else if (ce) begin
      wr_ptr    <= next_wr_ptr;
      rd_ptr    <= next_rd_ptr;
      count     <= next_count;
      out_valid <= next_out_valid;
      out_data  <= next_out_data;
    end
  end

  // Storage carries no reset; only entries behind the count are ever read.
  always_ff @(posedge sys_clk) begin
    if (resetn && ce && push_mem) begin
      mem[wr_ptr] <= in_data;
    end
  end

endmodule // slwp_fifo

// ### rtl/slwp_port.sv
/*
  Synchronous late-write SRAM port: command decode, burst counter, array,
  pipelined or flow-through read path and single or double late write path.
  Assumes all inputs are synchronous to sys_clk and a testbench resolves the
  data lanes from the lane enables.
*/
// Summary of operation
// R1: Gated clock edge freezes all internal state.
// R2: All inputs sampled on rising clock edge.
// R3: Controller loads address with advance low.
// R4: Selected only when all three selects active.
// R5: Any inactive select means deselect, no access.
// R6: Read starts: gate, selects, strobe high, load.
// R7: Read captures address and fetches the word.
// R8: Pipeline read data appears one edge later.
// R9: Write starts when selected with strobe low.
// R10: Four lane strobes pick written nine-bit lanes.
// R11: Write with no lane strobe is no-op.
// R12: Pipeline write data due two edges later.
// R13: Controller gives pipeline write data third edge.
// R14: Flow mode starts reads and bursts identically.
// R15: Flow mode read data one cycle sooner.
// R16: Flow mode write data one edge sooner.
// R17: Controller gives flow write data second edge.
// R18: Mode select low chooses flow-through operation.
// R19: Advance high steps two-bit counter address.
// R20: Gated edge keeps read bus driven, write off.
// R21: Unstrobed lanes keep stored content on writes.
// R22: Write data pairs with its command's address.
`timescale 1ns/1ps
`include "slwp_consts.svh"

module slwp_port
  import slwp_pkg::*;
(
  input  wire logic                         sys_clk,
  input  wire logic                         resetn,
  input  wire logic                         clk_en,
  input  wire logic                         clock_gate_n,
  input  wire logic                         chip_sel_first_n,
  input  wire logic                         chip_sel_second,
  input  wire logic                         chip_sel_third_n,
  input  wire logic                         advance_load,
  input  wire logic                         write_strobe_n,
  input  wire logic                         byte_lane_strobe_a_n,
  input  wire logic                         byte_lane_strobe_b_n,
  input  wire logic                         byte_lane_strobe_c_n,
  input  wire logic                         byte_lane_strobe_d_n,
  input  wire logic [`SLWP_ADDR_W-3:0]      address_high,
  input  wire logic [1:0]                   burst_start_low_address,
  input  wire logic                         output_enable_n,
  input  wire logic                         pipe_or_flow_select_n,
  input  wire logic                         burst_order_linear_n,
  input  wire logic                         sleep_request,
  input  wire logic [`SLWP_LANE_W-1:0]      data_lane_a_in,
  input  wire logic [`SLWP_LANE_W-1:0]      data_lane_b_in,
  input  wire logic [`SLWP_LANE_W-1:0]      data_lane_c_in,
  input  wire logic [`SLWP_LANE_W-1:0]      data_lane_d_in,
  output logic      [`SLWP_LANE_W-1:0]      data_lane_a_out,
  output logic      [`SLWP_LANE_W-1:0]      data_lane_b_out,
  output logic      [`SLWP_LANE_W-1:0]      data_lane_c_out,
  output logic      [`SLWP_LANE_W-1:0]      data_lane_d_out,
  output logic                              data_lane_a_oe,
  output logic                              data_lane_b_oe,
  output logic                              data_lane_c_oe,
  output logic                              data_lane_d_oe
);

  localparam int AW = `SLWP_ADDR_W;
  localparam int DW = `SLWP_DATA_W;
  localparam int LW = `SLWP_LANE_W;
  localparam int NL = `SLWP_LANES;

  //////////////////////////////////////////////////////////////////////////////
  // Decoding helpers.

  // All three selects must be active at once; one inactive select deselects.
  function automatic logic is_selected(input logic first_n, input logic second,
                                       input logic third_n);
    return !first_n && second && !third_n;
  endfunction

  // Low two address bits of a burst beat, linear or interleaved order.
  function automatic logic [1:0] burst_low(input logic [1:0] start, input logic [1:0] cnt,
                                           input logic linear);
    return linear ? 2'(start + cnt) : (start ^ cnt);
  endfunction

  // Replaces only the strobed lanes of a word; unstrobed lanes keep their value.
  function automatic logic [DW-1:0] lane_merge(input logic [DW-1:0] old_word,
                                               input logic [DW-1:0] new_word,
                                               input logic [NL-1:0] lanes);
    logic [DW-1:0] res;
    res = old_word;
    for (int i = 0; i < NL; i++) begin
      if (lanes[i]) begin
        res[i*LW +: LW] = new_word[i*LW +: LW];
      end
    end
    return res;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Declarations.

  logic [DW-1:0]             array [0:`SLWP_WORDS-1];
  logic                      ce;
  logic                      flow;
  logic                      sel;
  logic                      load;
  logic [NL-1:0]             lane_wr;
  logic [DW-1:0]             data_in;
  slwp_cmd_t                 burst_cmd;
  slwp_cmd_t                 next_burst_cmd;
  logic [AW-1:0]             base_addr;
  logic [AW-1:0]             next_base_addr;
  logic [1:0]                burst_cnt;
  logic [1:0]                next_burst_cnt;
  logic [AW-1:0]             cur_addr;
  logic                      do_rd;
  logic                      do_wr;
  logic [1:0]                wr_pend;
  logic [1:0]                next_wr_pend;
  logic                      commit;
  logic                      push_ready;
  logic                      head_valid;
  logic [`SLWP_ENTRY_W-1:0]  head;
  logic [AW-1:0]             head_addr;
  logic [NL-1:0]             head_lanes;
  logic [DW-1:0]             rd_word;
  logic [DW-1:0]             rd_stage;
  logic [DW-1:0]             next_rd_stage;
  logic                      rd_valid;
  logic                      next_rd_valid;
  logic [DW-1:0]             data_out;
  logic [DW-1:0]             next_data_out;
  logic [NL-1:0]             data_oe;
  logic [NL-1:0]             next_data_oe;
  logic [LW-1:0]             keep_lane_a;

  //////////////////////////////////////////////////////////////////////////////
  // Command decode and burst counter.

  // A high gate or a low system enable blocks the edge for every register.
  assign ce      = clk_en && !clock_gate_n;                                     // R1
  assign flow    = !pipe_or_flow_select_n;                                      // R18
  assign sel     = is_selected(chip_sel_first_n, chip_sel_second, chip_sel_third_n); // R4
  assign lane_wr = ~{byte_lane_strobe_d_n, byte_lane_strobe_c_n,
                     byte_lane_strobe_b_n, byte_lane_strobe_a_n};               // R10
  assign data_in = {data_lane_d_in, data_lane_c_in, data_lane_b_in, data_lane_a_in};

  // A load cycle starts a burst from the pins; a continue cycle repeats the
  // burst's operation at the next counter address. Sleep acts as a deselect.
  always_comb begin
    load = !advance_load;
    if (sleep_request) begin
      next_burst_cmd = SLWP_CMD_IDLE;
    end else if (load) begin
      if (!sel) begin
        next_burst_cmd = SLWP_CMD_IDLE;                                         // R5
      end else if (write_strobe_n) begin
        next_burst_cmd = SLWP_CMD_READ;                                         // R6
      end else begin
        next_burst_cmd = SLWP_CMD_WRITE;                                        // R9
      end
    end else begin
      next_burst_cmd = burst_cmd;                                               // R14
    end
    next_burst_cnt = load ? 2'h0 : 2'(burst_cnt + 2'h1);                        // R19
    next_base_addr = load ? {address_high, burst_start_low_address} : base_addr; // R7
    cur_addr       = {next_base_addr[AW-1:2],
                      burst_low(next_base_addr[1:0], next_burst_cnt, !burst_order_linear_n)};
    do_rd          = (next_burst_cmd == SLWP_CMD_READ);
    // A full queue turns the write into a no-op rather than losing its pairing.
    do_wr          = (next_burst_cmd == SLWP_CMD_WRITE) && (|lane_wr) && push_ready; // R11
  end

  // Burst state registers; the counter wraps after four beats.
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      burst_cmd <= SLWP_CMD_IDLE;
      burst_cnt <= 2'h0;
      base_addr <= '0;
    end else if (ce) begin
      burst_cmd <= next_burst_cmd;                                              // R2
      burst_cnt <= next_burst_cnt;
      base_addr <= next_base_addr;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Pending writes: each accepted write queues its address and lane strobes,
  // and is popped on the edge at which its data is due on the lanes.

  slwp_fifo #(
    .WIDTH (`SLWP_ENTRY_W),
    .DEPTH (`SLWP_FIFO_DEPTH),
    .AW    (`SLWP_FIFO_AW)
  ) u_pending (
    .sys_clk   (sys_clk),
    .resetn    (resetn),
    .ce        (ce),
    .in_valid  (do_wr),
    .in_data   ({cur_addr, lane_wr}),
    .in_ready  (push_ready),
    .out_valid (head_valid),
    .out_data  (head),
    .out_ready (commit)
  );

  assign head_addr  = head[`SLWP_ENTRY_W-1:NL];
  assign head_lanes = head[NL-1:0];

  // Double late write in pipeline mode, single late write in flow mode.
  always_comb begin
    next_wr_pend = {wr_pend[0], do_wr};
    if (flow) begin
      commit = head_valid && wr_pend[`SLWP_FLOW_WR_LAT-1];                      // R16
    end else begin
      commit = head_valid && wr_pend[`SLWP_PIPE_WR_LAT-1];                      // R12
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      wr_pend <= 2'h0;
    end else if (ce) begin
      wr_pend <= next_wr_pend;
    end
  end

  // The array has no reset; a write only touches its strobed lanes.
  always_ff @(posedge sys_clk) begin
    if (resetn && ce && commit) begin
      array[head_addr] <= lane_merge(array[head_addr], data_in, head_lanes);   // R21 R22
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read path. A write committing on this edge to the read address is
  // forwarded, so a read launched on that same edge sees the new data. A read whose
  // address has a write still waiting for its data sees the old word.

  always_comb begin
    rd_word = array[cur_addr];                                                  // R7
    if (commit && (head_addr == cur_addr)) begin
      rd_word = lane_merge(rd_word, data_in, head_lanes);
    end
    keep_lane_a   = array[head_addr][LW-1:0];
    next_rd_stage = rd_word;
    next_rd_valid = do_rd;
    if (flow) begin
      next_data_out = rd_word;                                                  // R15
      next_data_oe  = {NL{do_rd && !output_enable_n && !sleep_request}};
    end else begin
      next_data_out = rd_stage;                                                 // R8
      next_data_oe  = {NL{rd_valid && !output_enable_n && !sleep_request}};
    end
  end

  // Output registers hold across a gated edge, so a read stays on the bus and
  // a write cycle stays off it.
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      rd_stage <= '0;
      rd_valid <= 1'b0;
      data_out <= '0;
      data_oe  <= '0;
    end else if (ce) begin
      rd_stage <= next_rd_stage;
      rd_valid <= next_rd_valid;
      data_out <= next_data_out;
      data_oe  <= next_data_oe;
    end
  end                                                                           // R20

  assign data_lane_a_out = data_out[0*LW +: LW];
  assign data_lane_b_out = data_out[1*LW +: LW];
  assign data_lane_c_out = data_out[2*LW +: LW];
  assign data_lane_d_out = data_out[3*LW +: LW];
  assign data_lane_a_oe  = data_oe[0];
  assign data_lane_b_oe  = data_oe[1];
  assign data_lane_c_oe  = data_oe[2];
  assign data_lane_d_oe  = data_oe[3];

  //////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  sequence s_pipe_rd;
    ce && do_rd && !flow ##1 ce && !flow && !output_enable_n && !sleep_request;
  endsequence

  sequence s_pipe_wr;
    ce && do_wr && !flow ##1 ce && !flow ##1 ce && !flow;
  endsequence

  sequence s_flow_wr;
    ce && do_wr && flow ##1 ce && flow;
  endsequence

  AST_FREEZE: assert property (!ce |=> $stable(data_out) && $stable(data_oe)    // R1
    && $stable(burst_cnt)) else $error("State moved on a gated edge.");
  AST_DESELECT: assert property (ce && !sel && !advance_load |=>                // R5
    burst_cmd == SLWP_CMD_IDLE) else $error("Deselect did not idle.");
  AST_READ_START: assert property (ce && sel && write_strobe_n && !advance_load // R6
    && !sleep_request |=> burst_cmd == SLWP_CMD_READ) else $error("Read not started.");
  AST_WRITE_START: assert property (ce && sel && !write_strobe_n && !advance_load // R9
    && !sleep_request |=> burst_cmd == SLWP_CMD_WRITE) else $error("Write not started.");
  AST_PIPE_READ: assert property (s_pipe_rd |=> data_oe == 4'hF)               // R8
    else $error("Pipeline read data not driven two edges on.");
  AST_FLOW_READ: assert property (ce && do_rd && flow && !output_enable_n      // R15
    && !sleep_request |=> data_oe == 4'hF && data_out == $past(rd_word))
    else $error("Flow read data not driven one edge on.");
  AST_NOOP_WRITE: assert property (ce && next_burst_cmd == SLWP_CMD_WRITE      // R11
    && lane_wr == 4'h0 |=> !wr_pend[0]) else $error("Strobeless write queued.");
  AST_DOUBLE_LATE: assert property (s_pipe_wr |-> commit)                      // R12
    else $error("Pipeline write data not taken on the third edge.");
  AST_SINGLE_LATE: assert property (s_flow_wr |-> commit)                      // R16
    else $error("Flow write data not taken on the second edge.");
  AST_BURST_STEP: assert property (ce && advance_load |=>                     // R19
    burst_cnt == 2'($past(burst_cnt) + 2'h1)) else $error("Burst counter did not step.");
  AST_LANE_KEEP: assert property (ce && commit && !head_lanes[0] |=>            // R21
    array[$past(head_addr)][LW-1:0] == $past(keep_lane_a))
    else $error("Unstrobed lane changed.");

endmodule // slwp_port

// ### testbench/slwp_ctrl_model.sv
/*
  Controller-side model of the late-write SRAM port: drives each posted write
  word onto the data lanes for the one enabled edge at which it is due.
  Assumes the bench posts a word at its command edge, with that mode's latency.
*/
`timescale 1ns/1ps

module slwp_ctrl_model (
  input  wire logic       sys_clk,
  input  wire logic       resetn,
  input  wire logic       clk_en,
  input  wire logic       clock_gate_n,
  output logic      [8:0] data_lane_a_in,
  output logic      [8:0] data_lane_b_in,
  output logic      [8:0] data_lane_c_in,
  output logic      [8:0] data_lane_d_in
);
  logic [35:0] word_q[$];
  int          due_q[$];
  logic [35:0] lanes = 36'h0;

  assign {data_lane_d_in, data_lane_c_in, data_lane_b_in, data_lane_a_in} = lanes;

  // Queue a word that is due after lat enabled edges.
  task automatic post(input logic [35:0] word, input int lat);
    word_q.push_back(word);
    due_q.push_back(lat);
  endtask

  ////////////////////////////////////////
  // Only enabled edges move the slot; a released lane shows the inverse of its last value, so a stale word returns on every second enabled edge.
  always @(posedge sys_clk) begin
    if (!resetn) begin
      word_q.delete();
      due_q.delete();
    end else if (clk_en && !clock_gate_n) begin
      foreach (due_q[i]) due_q[i]--;
      #1;
      if (due_q.size() > 0 && due_q[0] == 0) begin
        void'(due_q.pop_front());
        lanes = word_q.pop_front();
      end else begin
        lanes = ~lanes;
      end
    end
  end
endmodule // slwp_ctrl_model

// ### testbench/slwp_port_bench.sv
/*
  Self-checking bench of the late-write SRAM port in pipeline and flow modes.
  Assumes slwp_ctrl_model supplies write data at the slot the bench posts.
*/
`timescale 1ns/1ps

module slwp_port_bench;
  logic        sys_clk, resetn, clk_en, clock_gate_n;
  logic        chip_sel_first_n, chip_sel_second, chip_sel_third_n, sleep_request;
  logic        advance_load, write_strobe_n, output_enable_n;
  logic        pipe_or_flow_select_n, burst_order_linear_n;
  logic        byte_lane_strobe_a_n, byte_lane_strobe_b_n;
  logic        byte_lane_strobe_c_n, byte_lane_strobe_d_n;
  logic [16:0] address_high;
  logic [1:0]  burst_start_low_address;
  logic [8:0]  data_lane_a_in, data_lane_b_in, data_lane_c_in, data_lane_d_in;
  logic [8:0]  data_lane_a_out, data_lane_b_out, data_lane_c_out, data_lane_d_out;
  logic        data_lane_a_oe, data_lane_b_oe, data_lane_c_oe, data_lane_d_oe;
  logic [35:0] mem[int];
  logic [35:0] exp_d[$];
  logic        exp_oe[$];
  int          exp_cnt[$];
  int          n_errors = 0, samples_checked = 0, op = 0, bcnt = 0, lat = 2;
  logic [18:0] base;
  logic [39:0] seen, held;
  logic        act;
  logic [3:0]  pat[6] = '{4'hE, 4'hD, 4'hB, 4'h7, 4'hF, 4'h9};

  assign seen = {data_lane_d_oe, data_lane_c_oe, data_lane_b_oe, data_lane_a_oe,
                 data_lane_d_out, data_lane_c_out, data_lane_b_out, data_lane_a_out};

  slwp_port u_slwp_port (
    .sys_clk, .resetn, .clk_en, .clock_gate_n, .chip_sel_first_n, .chip_sel_second,
    .chip_sel_third_n, .advance_load, .write_strobe_n, .byte_lane_strobe_a_n,
    .byte_lane_strobe_b_n, .byte_lane_strobe_c_n, .byte_lane_strobe_d_n, .address_high,
    .burst_start_low_address, .output_enable_n, .pipe_or_flow_select_n,
    .burst_order_linear_n, .sleep_request, .data_lane_a_in, .data_lane_b_in,
    .data_lane_c_in, .data_lane_d_in, .data_lane_a_out, .data_lane_b_out,
    .data_lane_c_out, .data_lane_d_out, .data_lane_a_oe, .data_lane_b_oe,
    .data_lane_c_oe, .data_lane_d_oe
  );

  slwp_ctrl_model u_slwp_ctrl_model (
    .sys_clk, .resetn, .clk_en, .clock_gate_n,
    .data_lane_a_in, .data_lane_b_in, .data_lane_c_in, .data_lane_d_in
  );

  // Free-running 200 MHz clock.
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  ////////////////////////////////////////
  // Counts every comparison and reports a mismatch at once.
  task automatic check(input string what, input logic [39:0] exp, input logic [39:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Single place where the run ends.
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // One enabled edge: drive a command, log what it must show, then let the edge pass.
  task automatic cyc(input logic ld, input logic wr_n, input logic [18:0] a,
                     input logic [3:0] sn, input logic [35:0] wd, input int dsel);
    logic [18:0] ea;
    logic [35:0] w;
    chip_sel_first_n = (dsel == 1);
    chip_sel_second  = (dsel != 2);
    chip_sel_third_n = (dsel == 3);
    sleep_request    = (dsel == 4);
    advance_load     = !ld;
    write_strobe_n   = wr_n;
    {byte_lane_strobe_d_n, byte_lane_strobe_c_n} = sn[3:2];
    {byte_lane_strobe_b_n, byte_lane_strobe_a_n} = sn[1:0];
    {address_high, burst_start_low_address} = a;
    if (ld) begin
      op   = (dsel != 0) ? 0 : (wr_n ? 1 : 2);
      base = a;
      bcnt = 0;
    end else begin
      bcnt = bcnt + 1;
    end
    ea = {base[18:2], burst_order_linear_n ? base[1:0] ^ 2'(bcnt) : base[1:0] + 2'(bcnt)};
    w = mem.exists(ea) ? mem[ea] : 36'h0;
    if (op == 2) begin
      for (int i = 0; i < 4; i++) if (!sn[i]) w[9*i +: 9] = wd[9*i +: 9];
      mem[ea] = w;
      u_slwp_ctrl_model.post(wd, lat);
    end
    exp_d.push_back(w);
    exp_oe.push_back(op == 1 && !output_enable_n);
    exp_cnt.push_back(lat);
    @(posedge sys_clk);
    #1;
  endtask

  // Deselected edges keep the bus quiet between scenarios.
  task automatic idle(input int n);
    repeat (n) cyc(1'b1, 1'b1, 19'h0, 4'hF, 36'h0, 1);
  endtask

  // Freezes n edges through the device gate or the system enable.
  task automatic stall(input int n, input logic use_en);
    repeat (n) begin
      if (use_en) clk_en = 1'b0;
      else clock_gate_n = 1'b1;
      @(posedge sys_clk);
      #1;
    end
    clk_en       = 1'b1;
    clock_gate_n = 1'b0;
  endtask

  // Enabled edges retire expectations; frozen edges must leave every output alone.
  always @(posedge sys_clk) begin
    act = resetn && clk_en && !clock_gate_n;
    if (act) foreach (exp_cnt[i]) exp_cnt[i]--;
    #1;
    if (act && exp_cnt.size() > 0 && exp_cnt[0] == 0) begin
      void'(exp_cnt.pop_front());
      if (exp_oe[0]) check("read word", {4'hF, exp_d[0]}, seen);
      else check("lane enables", 40'h0, 40'(seen[39:36]));
      void'(exp_oe.pop_front());
      void'(exp_d.pop_front());
    end else if (!act && resetn) begin
      check("stalled lanes", held, seen);
    end
    held = seen;
  end

  ////////////////////////////////////////
  // Every scenario in one mode; a reset separates the modes since a switch mid-flight is undefined.
  task automatic run_mode(input logic pipe);
    resetn = 1'b0;
    pipe_or_flow_select_n = pipe;
    lat = pipe ? 2 : 1;
    repeat (5) @(posedge sys_clk);
    #1;
    resetn = 1'b1;
    check("reset lanes", 40'h0, seen);
    for (int i = 0; i < 8; i++) cyc(1, 0, 19'h100 + 19'(i), 4'h0, {4{9'(i)}} ^ 36'h9A5C3F10E, 0);
    foreach (pat[i]) cyc(1, 0, 19'h100 + 19'(i), pat[i], 36'h5A5A5A5A5 ^ 36'(i), 0);
    for (int d = 1; d < 5; d++) cyc(1, 0, 19'h106, 4'h0, 36'h0, d);
    for (int i = 0; i < 8; i++) cyc(1, 1, 19'h100 + 19'(i), 4'h0, 36'h0, 0);
    cyc(1, 0, 19'h10C, 4'h0, 36'h3C3C3C3C3, 0);
    cyc(1, 1, 19'h107, 4'h0, 36'h0, 0);
    burst_order_linear_n = 1'b0;
    for (int i = 0; i < 4; i++) cyc(i == 0, 0, 19'h10A, 4'h0, 36'h0F0F0F0F0 + 36'(i), 0);
    idle(2);
    burst_order_linear_n = 1'b1;
    for (int i = 0; i < 4; i++) cyc(i == 0, 1, 19'h109, 4'h0, 36'h0, 0);
    cyc(1, 1, 19'h100, 4'h0, 36'h0, 0);
    stall(2, 1'b0);
    stall(1, 1'b1);
    cyc(1, 0, 19'h10D, 4'h0, 36'h777777777, 0);
    stall(2, 1'b0);
    idle(2);
    for (int i = 12; i < 14; i++) cyc(1, 1, 19'h100 + 19'(i), 4'h0, 36'h0, 0);
    // A pipelined read samples the output enable on the edge after its launch, so let that edge pass for the last one.
    idle(1);
    output_enable_n = 1'b1;
    cyc(1, 1, 19'h100, 4'h0, 36'h0, 0);
    idle(1);
    output_enable_n = 1'b0;
    for (int t = 0; t < 10 && exp_cnt.size() > 0; t++) begin
      @(posedge sys_clk);
      #1;
    end
    // A stuck expectation is counted once and dropped so the next mode starts clean.
    if (exp_cnt.size() > 0) begin
      n_errors++;
      $display("CHECK FAILED drain expected 0 seen %0d", exp_cnt.size());
      exp_cnt.delete();
      exp_oe.delete();
      exp_d.delete();
    end
    $display("test pipeline=%0d done", pipe);
  endtask

  // Known values on every input at time zero, then both modes.
  initial begin
    {clk_en, clock_gate_n, output_enable_n, burst_order_linear_n} = 4'h8;
    {chip_sel_first_n, chip_sel_second, chip_sel_third_n, sleep_request} = 4'hA;
    {advance_load, write_strobe_n, pipe_or_flow_select_n} = 3'h3;
    {byte_lane_strobe_a_n, byte_lane_strobe_b_n} = 2'h3;
    {byte_lane_strobe_c_n, byte_lane_strobe_d_n} = 2'h3;
    {address_high, burst_start_low_address} = 19'h0;
    run_mode(1'b1);
    run_mode(1'b0);
    test_done();
  end
endmodule // slwp_port_bench
